/* rtl/cid_pkg.sv */
// package for the compact instruction decoder and fetch aligner
// assumes a 32-bit core that supplies fetch words and register read data
package cid_pkg;
  localparam int          HALF_W         = 16;
  localparam int          WORD_W         = 32;
  localparam int          REG_IDX_W      = 5;
  // major opcodes, bits 15..11
  localparam logic [4:0]  OP_REG_REG_IMM_ADD_GROUP       = 5'h08;
  localparam logic [4:0]  OP_ADD_IMM8    = 5'h09;
  localparam logic [4:0]  OP_IMM8_MISC   = 5'h0C;
  localparam logic [4:0]  OP_THREE_REG   = 5'h1C;
  localparam logic [4:0]  OP_REG_REG     = 5'h1D;
  localparam logic [4:0]  OP_EXTEND      = 5'h1E;
  localparam logic [4:0]  OP_JAL         = 5'h03;
  // field positions
  localparam int          MAJ_LSB        = 11;
  localparam int          RX_LSB         = 8;
  localparam int          RY_LSB         = 5;
  localparam int          FRAME_SAVE_RESTORE_GROUP_BIT       = 7;
  localparam int          RRIA_F_BIT     = 4;
  // register translation
  localparam logic [4:0]  XLAT_R0        = 5'h10;
  localparam logic [4:0]  XLAT_R1        = 5'h11;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  typedef enum {
    CID_OP_NONE, CID_OP_RESERVED,
    CID_OP_BRANCH_T_ZERO, CID_OP_BRANCH_T_NONZERO, CID_OP_STORE_RA_STACK, CID_OP_SP_ADJUST,
    CID_OP_SAVE, CID_OP_RESTORE, CID_OP_MOVE_TO_FULL_REG, CID_OP_MOVE_FROM_FULL_REG,
    CID_OP_ADD_WORD_UNSIGNED, CID_OP_SUB_WORD_UNSIGNED,
    CID_OP_JUMP_RX, CID_OP_JUMP_RA, CID_OP_JUMP_LINK_REG, CID_OP_COMPACT_JUMP_RX,
    CID_OP_COMPACT_JUMP_RA, CID_OP_COMPACT_JUMP_LINK_REG,
    CID_OP_DEBUG_BREAKPOINT, CID_OP_SET_ON_LESS, CID_OP_SET_ON_LESS_UNSIGNED,
    CID_OP_VAR_SHIFT_LEFT, CID_OP_BREAK, CID_OP_VAR_SHIFT_RIGHT_LOGICAL, CID_OP_VAR_SHIFT_RIGHT_ARITH,
    CID_OP_COMPARE, CID_OP_NEGATE, CID_OP_AND, CID_OP_OR, CID_OP_XOR, CID_OP_NOT,
    CID_OP_MOVE_FROM_HIGH, CID_OP_MOVE_FROM_LOW,
    CID_OP_ZERO_EXTEND_BYTE, CID_OP_ZERO_EXTEND_HALF, CID_OP_SIGN_EXTEND_BYTE, CID_OP_SIGN_EXTEND_HALF,
    CID_OP_SIGNED_MULTIPLY, CID_OP_UNSIGNED_MULTIPLY, CID_OP_SIGNED_DIVIDE, CID_OP_UNSIGNED_DIVIDE,
    CID_OP_ADD_IMM_SHORT, CID_OP_ADD_IMM_EXT, CID_OP_ADD_IMM_THREE,
    CID_OP_OTHER
  } cid_op_t;

  typedef struct packed {
    logic        valid;
    logic        big_endian;
    logic        uncacheable;
    logic [31:0] word;
  } cid_fetch_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dst;
    logic [31:0] data;
  } cid_wb_t;
endpackage

/* rtl/cid_decoder.sv */
// compact instruction fetch aligner, minor-field decoder and add-immediate executor
// assumes the core presents one fetch word at a time with endianness and cacheability,
// and returns register read data in the same cycle for the requested source index
`timescale 1ns/10ps
// How it works
// - imm8 misc funct bits 10..8 select branch, stack, save/restore, move ops
// - three-reg bits 1..0: 01 add, 11 subtract, 00 and 10 reserved
// - reg-reg funct 00 row: jumps, breakpoint, compares, variable shifts, break
// - reg-reg funct 01 row: compare, negate, logic ops; 000, 001 reserved
// - reg-reg rows 10 and 11: move hi/lo, convert, multiply, divide
// - save/restore group: bit 7 zero restores, one saves
// - jump group ry field picks jump, link and compact forms
// - convert group ry field picks zero or sign extension of byte/half
// - big endian: first halfword from bits 31..16, second from 15..0
// - little endian: first halfword from bits 15..0, second from 31..16
// - extended and jump-and-link halves follow the same halfword order
// - uncacheable fetch requests never exceed one aligned word
// - 3-bit register codes 0 and 1 map to 16 and 17, others unchanged
// - short add-immediate sign-extends 8 bits and writes back to rx
// - extended add-immediate assembles 16-bit immediate from prefix and second half
// - three-operand add-immediate adds sign-extended 4 bits, writes ry
// - all adds wrap modulo 2^32 and never signal overflow
// - higher-level-only encodings raise reserved-instruction
// - non-extensible instruction after a prefix raises reserved-instruction
module cid_decoder (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  cid_pkg::cid_fetch_t         fetch,
  input  wire logic [31:0]            rx_data,
  output logic                        fetch_word_req_reg,
  output logic                        fetch_half_req_reg,
  output logic [4:0]                  rx_idx_reg,
  output cid_pkg::cid_op_t            op_reg,
  output logic                        reserved_exc_reg,
  output cid_pkg::cid_wb_t            wb_reg
);
  import cid_pkg::*;

  // halfword slot 0 is always executed first
  wire [15:0] first_half;
  wire [15:0] second_half;

  // each bit of a slot steers from the upper or lower half by endianness
  for (genvar b = 0; b < HALF_W; b++) begin : g_half
    wire hi_bit = fetch.word[HALF_W + b];
    wire lo_bit = fetch.word[b];
    assign first_half[b]  = fetch.big_endian ? hi_bit : lo_bit;
    assign second_half[b] = fetch.big_endian ? lo_bit : hi_bit;
  end

  // prefix held across halves and words so extended forms pair in fetch order
  logic        pfx_valid_reg;
  logic        pfx_valid_next;
  logic [10:0] pfx_bits_reg;
  logic [10:0] pfx_bits_next;
  logic [15:0] ins;
  logic        ins_valid;
  logic        slot_reg;
  logic        slot_next;

  // one halfword is consumed per cycle; slot selects which
  assign ins       = slot_reg ? second_half : first_half;
  assign ins_valid = fetch.valid;
  assign slot_next = ins_valid ? ~slot_reg : slot_reg;

  wire [4:0] major  = ins[15:MAJ_LSB];
  wire [2:0] f_i8   = ins[10:8];
  wire [1:0] f_rrr  = ins[1:0];
  wire [1:0] f_row  = ins[4:3];
  wire [2:0] f_col  = ins[2:0];
  wire [2:0] ry_fld = ins[7:5];
  wire [2:0] rx_fld = ins[10:8];
  wire       is_pfx = ins_valid && (major == OP_EXTEND);

  function automatic logic [4:0] xlat(input logic [2:0] code);
    xlat = (code == 3'h0) ? XLAT_R0 : (code == 3'h1) ? XLAT_R1 : {2'h0, code};
  endfunction

  // translated indices feed the register file read and the write-back
  wire [4:0] rx_phys = xlat(rx_fld);
  wire [4:0] ry_phys = xlat(ry_fld);

  cid_op_t op_dec;
  // cleared for halfwords that may not follow an extend prefix
  logic    extensible;

  always_comb begin
    op_dec     = CID_OP_OTHER;
    extensible = 1'b1;
    case (major)
      OP_IMM8_MISC: begin
        case (f_i8)
          3'h0: op_dec = CID_OP_BRANCH_T_ZERO;
          3'h1: op_dec = CID_OP_BRANCH_T_NONZERO;
          3'h2: op_dec = CID_OP_STORE_RA_STACK;
          3'h3: op_dec = CID_OP_SP_ADJUST;
          3'h4: op_dec = ins[FRAME_SAVE_RESTORE_GROUP_BIT] ? CID_OP_SAVE : CID_OP_RESTORE;
          3'h5: begin
            op_dec = CID_OP_MOVE_TO_FULL_REG;
            extensible = 1'b0;
          end
          3'h7: begin
            op_dec = CID_OP_MOVE_FROM_FULL_REG;
            extensible = 1'b0;
          end
          default: op_dec = CID_OP_RESERVED;
        endcase
      end
      OP_THREE_REG: begin
        extensible = 1'b0;
        case (f_rrr)
          2'h1: op_dec = CID_OP_ADD_WORD_UNSIGNED;
          2'h3: op_dec = CID_OP_SUB_WORD_UNSIGNED;
          default: op_dec = CID_OP_RESERVED;
        endcase
      end
      OP_REG_REG: begin
        extensible = 1'b0;
        op_dec = CID_OP_RESERVED;
        case ({f_row, f_col})
          5'h00: begin
            case (ry_fld)
              3'h0: op_dec = CID_OP_JUMP_RX;
              3'h1: op_dec = CID_OP_JUMP_RA;
              3'h2: op_dec = CID_OP_JUMP_LINK_REG;
              3'h4: op_dec = CID_OP_COMPACT_JUMP_RX;
              3'h5: op_dec = CID_OP_COMPACT_JUMP_RA;
              3'h6: op_dec = CID_OP_COMPACT_JUMP_LINK_REG;
              default: op_dec = CID_OP_RESERVED;
            endcase
          end
          5'h01: op_dec = CID_OP_DEBUG_BREAKPOINT;
          5'h02: op_dec = CID_OP_SET_ON_LESS;
          5'h03: op_dec = CID_OP_SET_ON_LESS_UNSIGNED;
          5'h04: op_dec = CID_OP_VAR_SHIFT_LEFT;
          5'h05: op_dec = CID_OP_BREAK;
          5'h06: op_dec = CID_OP_VAR_SHIFT_RIGHT_LOGICAL;
          5'h07: op_dec = CID_OP_VAR_SHIFT_RIGHT_ARITH;
          5'h0A: op_dec = CID_OP_COMPARE;
          5'h0B: op_dec = CID_OP_NEGATE;
          5'h0C: op_dec = CID_OP_AND;
          5'h0D: op_dec = CID_OP_OR;
          5'h0E: op_dec = CID_OP_XOR;
          5'h0F: op_dec = CID_OP_NOT;
          5'h10: op_dec = CID_OP_MOVE_FROM_HIGH;
          5'h11: begin
            case (ry_fld)
              3'h0: op_dec = CID_OP_ZERO_EXTEND_BYTE;
              3'h1: op_dec = CID_OP_ZERO_EXTEND_HALF;
              3'h4: op_dec = CID_OP_SIGN_EXTEND_BYTE;
              3'h5: op_dec = CID_OP_SIGN_EXTEND_HALF;
              default: op_dec = CID_OP_RESERVED;
            endcase
          end
          5'h12: op_dec = CID_OP_MOVE_FROM_LOW;
          5'h18: op_dec = CID_OP_SIGNED_MULTIPLY;
          5'h19: op_dec = CID_OP_UNSIGNED_MULTIPLY;
          5'h1A: op_dec = CID_OP_SIGNED_DIVIDE;
          5'h1B: op_dec = CID_OP_UNSIGNED_DIVIDE;
          default: op_dec = CID_OP_RESERVED;
        endcase
      end
      // with a prefix pending only the form with bits 7..5 at zero pairs
      OP_ADD_IMM8: begin
        if (pfx_valid_reg && (ry_fld == 3'h0)) begin
          op_dec = CID_OP_ADD_IMM_EXT;
        end else if (pfx_valid_reg) begin
          op_dec = CID_OP_RESERVED;
        end else begin
          op_dec = CID_OP_ADD_IMM_SHORT;
        end
      end
      OP_REG_REG_IMM_ADD_GROUP: begin
        op_dec = ins[RRIA_F_BIT] ? CID_OP_RESERVED : CID_OP_ADD_IMM_THREE;
      end
      default: op_dec = CID_OP_OTHER;
    endcase
  end

  // immediates, sign-extended to the full word
  wire [15:0] imm_ext16 = {pfx_bits_reg[4:0], pfx_bits_reg[10:5], ins[4:0]};
  wire [31:0] imm_short = {{24{ins[7]}}, ins[7:0]};
  wire [31:0] imm_ext   = {{16{imm_ext16[15]}}, imm_ext16};
  wire [31:0] imm_three = {{28{ins[3]}}, ins[3:0]};

  logic [31:0] addend;
  logic [4:0]  dst_idx;
  logic        is_add;
  always_comb begin
    addend  = ZERO_WORD;
    dst_idx = rx_phys;
    is_add  = 1'b1;
    case (op_dec)
      CID_OP_ADD_IMM_SHORT: addend = imm_short;
      CID_OP_ADD_IMM_EXT:   addend = imm_ext;
      CID_OP_ADD_IMM_THREE: begin
        addend  = imm_three;
        dst_idx = ry_phys;
      end
      default: is_add = 1'b0;
    endcase
  end

  // sum truncated to 32 bits, carry dropped and no overflow trap
  wire [31:0] sum = rx_data + addend;

  // a prefix followed by a non-extensible halfword is refused as well
  wire bad_ext  = pfx_valid_reg && !extensible && ins_valid && !is_pfx;
  wire rsv_code = (op_dec == CID_OP_RESERVED);
  wire exc      = ins_valid && !is_pfx && (rsv_code || bad_ext);

  assign pfx_valid_next = ins_valid ? is_pfx : pfx_valid_reg;
  assign pfx_bits_next  = is_pfx ? ins[10:0] : pfx_bits_reg;

  // next values of the outputs, each registered in its own short block below
  logic       word_req_next;
  logic       half_req_next;
  logic [4:0] rx_idx_next;
  cid_op_t    op_next;
  logic       exc_next;
  cid_wb_t    wb_next;

  // the next aligned word is asked for once the second halfword is taken
  assign word_req_next = ins_valid && slot_reg;
  // halfword-wide fetches are never issued, so uncacheable fetches stay one word
  assign half_req_next = 1'b0;
  assign rx_idx_next   = rx_phys;
  assign op_next       = (ins_valid && !is_pfx) ? op_dec : CID_OP_NONE;
  assign exc_next      = exc;
  assign wb_next       = '{valid: ins_valid && is_add && !exc, dst: dst_idx, data: sum};

  // slot flips only on taken halfwords, so an idle cycle keeps the pairing
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pfx_valid_reg <= 1'b0;
    end else begin
      pfx_valid_reg <= pfx_valid_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pfx_bits_reg <= 11'h000;
    end else begin
      pfx_bits_reg <= pfx_bits_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_word_req_reg <= 1'b0;
    end else begin
      fetch_word_req_reg <= word_req_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_half_req_reg <= 1'b0;
    end else begin
      fetch_half_req_reg <= half_req_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_idx_reg <= 5'h00;
    end else begin
      rx_idx_reg <= rx_idx_next;
    end
  end

  // prefix halves and idle cycles show no operation
  always_ff @(posedge clk) begin
    if (rst) begin
      op_reg <= CID_OP_NONE;
    end else begin
      op_reg <= op_next;
    end
  end

  // exception is a one-cycle pulse per offending halfword
  always_ff @(posedge clk) begin
    if (rst) begin
      reserved_exc_reg <= 1'b0;
    end else begin
      reserved_exc_reg <= exc_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_reg <= '0;
    end else begin
      wb_reg <= wb_next;
    end
  end
endmodule

/* testbench/cid_decoder_checker.sv */
// checker for the compact decoder: halfword order, translation, add forms, prefix pairing
// assumes one clock with synchronous active-high reset
`timescale 1ns/10ps
module cid_decoder_checker (
  input  wire logic           clk,
  input  wire logic           rst,
  input  cid_pkg::cid_fetch_t fetch,
  input  wire logic [31:0]    rx_data,
  input  wire logic           fetch_word_req_reg,
  input  wire logic           fetch_half_req_reg,
  input  wire logic [4:0]     rx_idx_reg,
  input  cid_pkg::cid_op_t    op_reg,
  input  wire logic           reserved_exc_reg,
  input  cid_pkg::cid_wb_t    wb_reg
);
  import cid_pkg::*;
  logic        slot_reg;
  logic        pend_reg;
  logic        took1_reg;
  logic [10:0] pimm_reg;
  logic [15:0] h;
  logic [4:0]  maj;
  logic [4:0]  xrx;
  logic [4:0]  xry;
  logic [31:0] sum8;
  logic [31:0] sum4;
  logic [31:0] sum16;
  assign h = (fetch.big_endian ^ slot_reg) ? fetch.word[31:16] : fetch.word[15:0];
  assign maj = h[15:11];
  assign xrx = (h[10:9] == 2'h0) ? {4'h8, h[8]} : {2'h0, h[10:8]};
  assign xry = (h[7:6] == 2'h0) ? {4'h8, h[5]} : {2'h0, h[7:5]};
  assign sum8 = rx_data + {{24{h[7]}}, h[7:0]};
  assign sum4 = rx_data + {{28{h[3]}}, h[3:0]};
  assign sum16 = rx_data + {{16{pimm_reg[10]}}, pimm_reg, h[4:0]};
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_reg <= 1'b0;
      pend_reg <= 1'b0;
      took1_reg <= 1'b0;
    end else begin
      took1_reg <= fetch.valid & slot_reg;
      if (fetch.valid) begin
        slot_reg <= ~slot_reg;
        pend_reg <= (maj == OP_EXTEND);
        pimm_reg <= {h[4:0], h[10:5]};
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_half_req_never: assert property (!fetch_half_req_reg) else $error("half fetch requested");
  a_word_req_slot1: assert property (fetch_word_req_reg == took1_reg) else $error("word request misplaced");
  a_rx_xlat: assert property (fetch.valid |=> rx_idx_reg == $past(xrx)) else $error("rx index wrong");
  a_short_add: assert property (fetch.valid && !pend_reg && maj == OP_ADD_IMM8 |=>
    wb_reg.valid && wb_reg.dst == $past(xrx) && wb_reg.data == $past(sum8)) else $error("short add wrong");
  a_ext_add: assert property (fetch.valid && pend_reg && maj == OP_ADD_IMM8 && h[7:5] == 3'h0 |=>
    wb_reg.valid && wb_reg.data == $past(sum16)) else $error("extended add wrong");
  a_three_add: assert property (fetch.valid && !pend_reg && maj == OP_REG_REG_IMM_ADD_GROUP && !h[4] |=>
    wb_reg.valid && wb_reg.dst == $past(xry) && wb_reg.data == $past(sum4)) else $error("three add wrong");
  a_prefix_quiet: assert property (fetch.valid && maj == OP_EXTEND |=>
    !wb_reg.valid && !reserved_exc_reg && op_reg == CID_OP_NONE) else $error("prefix not quiet");
  a_nonext_exc: assert property (fetch.valid && pend_reg && (maj == OP_THREE_REG || maj == OP_REG_REG) |=>
    reserved_exc_reg && !wb_reg.valid) else $error("prefixed op not refused");
  a_rrr_reserved: assert property (fetch.valid && !pend_reg && maj == OP_THREE_REG && !h[0] |=>
    reserved_exc_reg) else $error("reserved three-reg accepted");
  a_frame_sel: assert property (fetch.valid && !pend_reg && maj == OP_IMM8_MISC && h[10:8] == 3'h4 |=>
    op_reg == ($past(h[7]) ? CID_OP_SAVE : CID_OP_RESTORE)) else $error("save/restore wrong");
  c_short: cover property (fetch.valid && !pend_reg && maj == OP_ADD_IMM8);
  c_ext: cover property (fetch.valid && pend_reg && maj == OP_ADD_IMM8);
  c_exc: cover property (reserved_exc_reg);
endmodule
bind cid_decoder cid_decoder_checker u_chk (.clk(clk), .rst(rst), .fetch(fetch), .rx_data(rx_data),
  .fetch_word_req_reg(fetch_word_req_reg), .fetch_half_req_reg(fetch_half_req_reg),
  .rx_idx_reg(rx_idx_reg), .op_reg(op_reg), .reserved_exc_reg(reserved_exc_reg), .wb_reg(wb_reg));

/* testbench/cid_fetch_model.sv */
// fetch source model: hands queued words to the decoder, each for two valid cycles
// assumes the bench queues words after a rising edge; outputs change on the falling edge
`timescale 1ns/10ps
module cid_fetch_model (
  input  wire logic           clk,
  input  wire logic           rst,
  output cid_pkg::cid_fetch_t fetch
);
  import cid_pkg::*;
  cid_fetch_t q[$];
  logic       second_reg;
  initial begin
    fetch = '0;
    second_reg = 1'b0;
  end
  always @(negedge clk) begin
    if (!rst && second_reg) begin
      second_reg <= 1'b0;
    end else if (!rst && q.size() > 0 && q[0].valid) begin
      second_reg <= 1'b1;
      fetch <= q.pop_front();
    end else begin
      if (q.size() > 0) begin
        void'(q.pop_front());
      end
      fetch.valid <= 1'b0;
      // idle bus inverts the word every cycle, so the stale word returns on alternate idle cycles
      fetch.word <= ~fetch.word;
    end
  end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the compact decoder with a fetch source model
// assumes outputs answer one cycle after each taken halfword
`timescale 1ns/10ps
module tb_top;
  import cid_pkg::*;
  localparam cid_op_t rsv = CID_OP_RESERVED;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] rx_data = 32'h0000_0005;
  logic        took = 1'b0;
  cid_fetch_t  fetch;
  logic        word_req;
  logic        half_req;
  logic        exc;
  logic [4:0]  rx_idx;
  cid_op_t     op;
  cid_wb_t     wb;
  int          fails = 0;
  int          n_compared = 0;
  cid_op_t     eop[$];
  cid_op_t     oop[$];
  logic [38:0] ewb[$];
  logic [38:0] owb[$];
  cid_fetch_model u_mem (.clk(clk), .rst(rst), .fetch(fetch));
  cid_decoder u_dut (.clk(clk), .rst(rst), .fetch(fetch), .rx_data(rx_data), .fetch_word_req_reg(word_req),
    .fetch_half_req_reg(half_req), .rx_idx_reg(rx_idx), .op_reg(op), .reserved_exc_reg(exc), .wb_reg(wb));
  always #12.5 clk = ~clk;
  always @(posedge clk) took <= fetch.valid & ~rst;
  always @(negedge clk) begin
    if (took) begin
      oop.push_back(op);
      owb.push_back({exc, wb});
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, what, seen, exp);
    end
  endtask
  task automatic word(input logic be, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    u_mem.q.push_back({1'b1, be, 1'b1, be ? {a, b} : {b, a}});
  endtask
  task automatic ex(input cid_op_t o, input logic e, input logic v = 1'b0, input logic [4:0] d = 5'h00,
                    input logic [31:0] r = 32'h0000_0000);
    eop.push_back(o);
    ewb.push_back({e, v, d, r});
  endtask
  task automatic judge(input string what);
    logic [38:0] w;
    logic [38:0] x;
    for (int i = 0; i < 200 && u_mem.q.size() > 0; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    check(oop.size(), eop.size(), what);
    while (eop.size() > 0 && oop.size() > 0) begin
      w = ewb.pop_front();
      x = owb.pop_front();
      check(oop.pop_front(), eop.pop_front(), what);
      check(x[38:37], w[38:37], what);
      if (w[37]) check(x[36:0], w[36:0], what);
    end
    oop.delete();
    eop.delete();
    owb.delete();
    ewb.delete();
  endtask
  task automatic t_imm8();
    cid_op_t t[8] = '{CID_OP_BRANCH_T_ZERO, CID_OP_BRANCH_T_NONZERO, CID_OP_STORE_RA_STACK, CID_OP_SP_ADJUST,
                      CID_OP_RESTORE, CID_OP_MOVE_TO_FULL_REG, rsv, CID_OP_MOVE_FROM_FULL_REG};
    for (int i = 0; i < 8; i += 2) begin
      word(i[1], {OP_IMM8_MISC, 3'(i), 8'h00}, {OP_IMM8_MISC, 3'(i + 1), 8'h00});
      ex(t[i], i == 6);
      ex(t[i + 1], 1'b0);
    end
    word(1'b1, {OP_IMM8_MISC, 3'h4, 8'h80}, {OP_IMM8_MISC, 3'h4, 8'h7F});
    ex(CID_OP_SAVE, 1'b0);
    ex(CID_OP_RESTORE, 1'b0);
    judge("imm8 group");
  endtask
  task automatic t_rrr();
    word(1'b1, {OP_THREE_REG, 9'h000, 2'h0}, {OP_THREE_REG, 9'h000, 2'h1});
    word(1'b0, {OP_THREE_REG, 9'h000, 2'h2}, {OP_THREE_REG, 9'h000, 2'h3});
    ex(rsv, 1'b1);
    ex(CID_OP_ADD_WORD_UNSIGNED, 1'b0);
    ex(rsv, 1'b1);
    ex(CID_OP_SUB_WORD_UNSIGNED, 1'b0);
    judge("three-reg group");
  endtask
  task automatic t_rr();
    cid_op_t t[32] = '{CID_OP_JUMP_RX, CID_OP_DEBUG_BREAKPOINT, CID_OP_SET_ON_LESS, CID_OP_SET_ON_LESS_UNSIGNED,
      CID_OP_VAR_SHIFT_LEFT, CID_OP_BREAK, CID_OP_VAR_SHIFT_RIGHT_LOGICAL, CID_OP_VAR_SHIFT_RIGHT_ARITH,
      rsv, rsv, CID_OP_COMPARE, CID_OP_NEGATE, CID_OP_AND, CID_OP_OR, CID_OP_XOR, CID_OP_NOT,
      CID_OP_MOVE_FROM_HIGH, CID_OP_ZERO_EXTEND_BYTE, CID_OP_MOVE_FROM_LOW, rsv, rsv, rsv, rsv, rsv,
      CID_OP_SIGNED_MULTIPLY, CID_OP_UNSIGNED_MULTIPLY, CID_OP_SIGNED_DIVIDE, CID_OP_UNSIGNED_DIVIDE,
      rsv, rsv, rsv, rsv};
    for (int i = 0; i < 32; i += 2) begin
      word(i[1], {OP_REG_REG, 6'h00, 5'(i)}, {OP_REG_REG, 6'h00, 5'(i + 1)});
      ex(t[i], t[i] == rsv);
      ex(t[i + 1], t[i + 1] == rsv);
    end
    judge("reg-reg group");
  endtask
  task automatic t_ry();
    cid_op_t tj[8] = '{CID_OP_JUMP_RX, CID_OP_JUMP_RA, CID_OP_JUMP_LINK_REG, rsv, CID_OP_COMPACT_JUMP_RX,
                       CID_OP_COMPACT_JUMP_RA, CID_OP_COMPACT_JUMP_LINK_REG, rsv};
    cid_op_t tc[8] = '{CID_OP_ZERO_EXTEND_BYTE, CID_OP_ZERO_EXTEND_HALF, rsv, rsv,
                       CID_OP_SIGN_EXTEND_BYTE, CID_OP_SIGN_EXTEND_HALF, rsv, rsv};
    for (int j = 0; j < 8; j++) begin
      word(j[0], {OP_REG_REG, 3'h0, 3'(j), 5'h00}, {OP_REG_REG, 3'h0, 3'(j), 5'h11});
      ex(tj[j], tj[j] == rsv);
      ex(tc[j], tc[j] == rsv);
    end
    judge("jump and convert");
  endtask
  task automatic t_add();
    @(negedge clk);
    rx_data = 32'h7FFF_FFFF;
    word(1'b0, {OP_ADD_IMM8, 3'h0, 8'hFF}, {OP_ADD_IMM8, 3'h1, 8'h01});
    word(1'b1, {OP_REG_REG_IMM_ADD_GROUP, 3'h2, 3'h1, 1'b0, 4'hF}, {OP_EXTEND, 6'h00, 5'h10});
    u_mem.q.push_back('0);
    word(1'b0, {OP_ADD_IMM8, 3'h7, 3'h0, 5'h01}, {OP_REG_REG_IMM_ADD_GROUP, 6'h00, 1'b1, 4'h0});
    ex(CID_OP_ADD_IMM_SHORT, 1'b0, 1'b1, 5'h10, 32'h7FFF_FFFE);
    ex(CID_OP_ADD_IMM_SHORT, 1'b0, 1'b1, 5'h11, 32'h8000_0000);
    ex(CID_OP_ADD_IMM_THREE, 1'b0, 1'b1, 5'h11, 32'h7FFF_FFFE);
    ex(CID_OP_NONE, 1'b0);
    ex(CID_OP_ADD_IMM_EXT, 1'b0, 1'b1, 5'h07, 32'h7FFF_8000);
    ex(rsv, 1'b1);
    judge("add immediate forms");
  endtask
  task automatic t_prefix();
    @(negedge clk);
    rx_data = 32'h0000_0005;
    word(1'b1, {OP_EXTEND, 11'h000}, {OP_THREE_REG, 9'h000, 2'h1});
    word(1'b0, {OP_EXTEND, 11'h000}, {OP_ADD_IMM8, 3'h0, 3'h1, 5'h00});
    word(1'b1, {OP_EXTEND, 11'h000}, {OP_EXTEND, 6'h3F, 5'h1F});
    word(1'b0, {OP_ADD_IMM8, 3'h2, 3'h0, 5'h00}, {OP_IMM8_MISC, 3'h0, 8'h00});
    ex(CID_OP_NONE, 1'b0);
    ex(CID_OP_ADD_WORD_UNSIGNED, 1'b1);
    ex(CID_OP_NONE, 1'b0);
    ex(rsv, 1'b1);
    ex(CID_OP_NONE, 1'b0);
    ex(CID_OP_NONE, 1'b0);
    ex(CID_OP_ADD_IMM_EXT, 1'b0, 1'b1, 5'h02, 32'hFFFF_FFE5);
    ex(CID_OP_BRANCH_T_ZERO, 1'b0);
    judge("prefix pairing");
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_imm8();
    t_rrr();
    t_rr();
    t_ry();
    t_add();
    t_prefix();
    complete_run();
  end
endmodule
